// *** verilog/bst_defs.vh ***
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define BST_IR_WIDTH      3
`define BST_IR_EXTEST     3'h0
`define BST_IR_SAMPLE     3'h4
`define BST_IR_IDCODE     3'h6
`define BST_IR_BYPASS     3'h7
`define BST_IR_CAPTURE    3'h1
`define BST_IR_RESET      3'h6

// ----------------------------------------
// Data registers
// ----------------------------------------
`define BST_CHAIN_LEN     98
`define BST_ID_WIDTH      32
`define BST_ID_FIXED_BIT  0
`define BST_ID_PROD_LSB   1
`define BST_ID_PROD_MSB   11
`define BST_ID_PART_LSB   12
`define BST_ID_PART_MSB   27
`define BST_ID_REV_LSB    28
`define BST_ID_REV_MSB    31

// ----------------------------------------
// Data register selection codes
// ----------------------------------------
`define BST_SEL_BYPASS    2'h0
`define BST_SEL_CHAIN     2'h1
`define BST_SEL_ID        2'h2

`endif

// *** verilog/bst_chain.v ***
`timescale 1ns/1ps

`include "bst_defs.vh"

module bst_chain #(
    parameter LEN = `BST_CHAIN_LEN
) (
    input  wire           sys_clk,
    input  wire           sys_rst,
    input  wire           capture,
    input  wire           shift,
    input  wire           update,
    input  wire           serial_in,
    input  wire [LEN-1:0] parallel_in,
    output wire           serial_lsb,
    output reg  [LEN-1:0] parallel_out
);

    // ----------------------------------------
    // Shift stages
    // ----------------------------------------
    reg [LEN-1:0] stages;

    assign serial_lsb = stages[0];

    // Capture from pins, or shift toward serial output
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            stages <= {LEN{1'b0}};
        end else if (capture) begin
            stages <= parallel_in;
        end else if (shift) begin
            stages <= {serial_in, stages[LEN-1:1]};
        end
    end

    // ----------------------------------------
    // Latched parallel output
    // ----------------------------------------
    // Holds still while shifting; moves only on update strobe
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            parallel_out <= {LEN{1'b0}};
        end else if (update) begin
            parallel_out <= stages;
        end
    end

endmodule

// *** verilog/bst_tap.v ***
// Operation
// - Three-bit instruction, shifted in LSB first
// - Code 000 selects chain, captures pins
// - Code 000 drives pins from updated chain
// - Code 100 selects chain, normal pin path
// - Code 100 captures pin values in Capture-DR
// - Code 110 selects identification register
// - Code 111 gives one-clock bypass delay
// - Identification 32 bits, fixed one, fields
// - Identification shifted out LSB first
// - Bypass register is one bit
// - 98-bit chain used only by 000/100
// - Sixteen-state controller, DR and IR branches
// - Mode-select sampled on test-clock rising edge
// - One bit per test clock
// - Five high mode-select edges reach reset
// - Chain latch updates only in Update-DR
`timescale 1ns/1ps

`include "bst_defs.vh"

module bst_tap #(
    parameter [10:0] ID_PRODUCER = 11'h055, // Arbitrary value
    parameter [15:0] ID_PART     = 16'h1234, // Arbitrary value
    parameter [3:0]  ID_REVISION = 4'h1, // Arbitrary value
    parameter        CHAIN_LEN   = `BST_CHAIN_LEN
) (
    input  wire                 sys_clk,
    input  wire                 sys_rst,
    input  wire                 tck,
    input  wire                 tms,
    input  wire                 tdi,
    output reg                  tdo,
    output reg                  tdo_oe,
    input  wire [CHAIN_LEN-1:0] pin_capture,
    output wire [CHAIN_LEN-1:0] pin_test_value,
    output reg                  pin_test_drive
);

    // ----------------------------------------
    // Controller states
    // ----------------------------------------
    localparam [15:0] ST_RESET    = 16'h0001;
    localparam [15:0] ST_IDLE     = 16'h0002;
    localparam [15:0] ST_SEL_DR   = 16'h0004;
    localparam [15:0] ST_CAP_DR   = 16'h0008;
    localparam [15:0] ST_SHIFT_DR = 16'h0010;
    localparam [15:0] ST_EXIT1_DR = 16'h0020;
    localparam [15:0] ST_PAUSE_DR = 16'h0040;
    localparam [15:0] ST_EXIT2_DR = 16'h0080;
    localparam [15:0] ST_UPD_DR   = 16'h0100;
    localparam [15:0] ST_SEL_IR   = 16'h0200;
    localparam [15:0] ST_CAP_IR   = 16'h0400;
    localparam [15:0] ST_SHIFT_IR = 16'h0800;
    localparam [15:0] ST_EXIT1_IR = 16'h1000;
    localparam [15:0] ST_PAUSE_IR = 16'h2000;
    localparam [15:0] ST_EXIT2_IR = 16'h4000;
    localparam [15:0] ST_UPD_IR   = 16'h8000;

    localparam [`BST_ID_WIDTH-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_PRODUCER, 1'b1};

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Next controller state from mode-select
    function [15:0] bst_next;
        input [15:0] st;
        input        m;
        begin
            case (st)
                ST_RESET:    bst_next = m ? ST_RESET : ST_IDLE;
                ST_IDLE:     bst_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR:   bst_next = m ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR:   bst_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: bst_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: bst_next = m ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: bst_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: bst_next = m ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR:   bst_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR:   bst_next = m ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR:   bst_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: bst_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: bst_next = m ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: bst_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: bst_next = m ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR:   bst_next = m ? ST_SEL_DR : ST_IDLE;
                default:     bst_next = ST_RESET;
            endcase
        end
    endfunction

    // Data register picked by an instruction code
    function [1:0] bst_select;
        input [`BST_IR_WIDTH-1:0] code;
        begin
            if (code == `BST_IR_EXTEST || code == `BST_IR_SAMPLE) begin
                bst_select = `BST_SEL_CHAIN;
            end else if (code == `BST_IR_IDCODE) begin
                bst_select = `BST_SEL_ID;
            end else begin
                bst_select = `BST_SEL_BYPASS;
            end
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg tck_s1;
    reg tck_s2;
    reg tck_s3;
    reg tms_s1;
    reg tms_s2;
    reg tdi_s1;
    reg tdi_s2;

    // Two stages each, third tck stage for edges
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
        end else begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
        end
    end

    wire tck_rise = tck_s2 & ~tck_s3;
    wire tck_fall = ~tck_s2 & tck_s3;

    // ----------------------------------------
    // Controller
    // ----------------------------------------
    reg [15:0]              state;
    reg [`BST_IR_WIDTH-1:0] instr;
    reg [`BST_IR_WIDTH-1:0] ir_shift;

    wire [1:0] dr_sel = bst_select(instr);
    wire       sel_chain = (dr_sel == `BST_SEL_CHAIN);

    // State advances on each rising test-clock edge
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= bst_next(state, tms_s2);
        end
    end

    // Instruction shift stage and current instruction
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ir_shift <= `BST_IR_CAPTURE;
            instr    <= `BST_IR_RESET;
        end else if (state == ST_RESET) begin
            instr <= `BST_IR_RESET;
        end else if (tck_rise && state == ST_CAP_IR) begin
            ir_shift <= `BST_IR_CAPTURE;
        end else if (tck_rise && state == ST_SHIFT_IR) begin
            ir_shift <= {tdi_s2, ir_shift[`BST_IR_WIDTH-1:1]};
        end else if (tck_fall && state == ST_UPD_IR) begin
            instr <= ir_shift;
        end
    end

    // ----------------------------------------
    // Identification and bypass registers
    // ----------------------------------------
    reg [`BST_ID_WIDTH-1:0] id_shift;
    reg                     bypass_bit;

    // Load on capture, shift toward output LSB first
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            id_shift   <= {`BST_ID_WIDTH{1'b0}};
            bypass_bit <= 1'b0;
        end else if (tck_rise && state == ST_CAP_DR) begin
            if (dr_sel == `BST_SEL_ID) begin
                id_shift <= ID_VALUE;
            end
            if (dr_sel == `BST_SEL_BYPASS) begin
                bypass_bit <= 1'b0;
            end
        end else if (tck_rise && state == ST_SHIFT_DR) begin
            if (dr_sel == `BST_SEL_ID) begin
                id_shift <= {tdi_s2, id_shift[`BST_ID_WIDTH-1:1]};
            end
            if (dr_sel == `BST_SEL_BYPASS) begin
                bypass_bit <= tdi_s2;
            end
        end
    end

    // ----------------------------------------
    // Boundary chain
    // ----------------------------------------
    wire chain_lsb;
    wire chain_cap = tck_rise && state == ST_CAP_DR && sel_chain;
    wire chain_sh  = tck_rise && state == ST_SHIFT_DR && sel_chain;
    wire chain_upd = tck_fall && state == ST_UPD_DR && sel_chain;

    bst_chain #(
        .LEN          (CHAIN_LEN)
    ) u_chain (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .capture      (chain_cap),
        .shift        (chain_sh),
        .update       (chain_upd),
        .serial_in    (tdi_s2),
        .parallel_in  (pin_capture),
        .serial_lsb   (chain_lsb),
        .parallel_out (pin_test_value)
    );

    // Pins follow the chain only under external test
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_test_drive <= 1'b0;
        end else begin
            pin_test_drive <= (instr == `BST_IR_EXTEST);
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    reg dr_lsb;

    // Least significant bit of the selected path
    always @* begin
        case (dr_sel)
            `BST_SEL_CHAIN: dr_lsb = chain_lsb;
            `BST_SEL_ID:    dr_lsb = id_shift[0];
            default:        dr_lsb = bypass_bit;
        endcase
    end

    // Output and enable move on falling test-clock edges
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
            if (state == ST_SHIFT_IR) begin
                tdo <= ir_shift[0];
            end else if (state == ST_SHIFT_DR) begin
                tdo <= dr_lsb;
            end
        end
    end

endmodule

// *** testbench/bst_tap_assertions.sv ***
`timescale 1ns/1ps

module bst_tap_assertions #(
    parameter CHAIN_LEN = 98
) (
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    input wire logic                 tck,
    input wire logic                 tms,
    input wire logic                 tdi,
    input wire logic                 tdo,
    input wire logic                 tdo_oe,
    input wire logic [CHAIN_LEN-1:0] pin_capture,
    input wire logic [CHAIN_LEN-1:0] pin_test_value,
    input wire logic                 pin_test_drive
);
    logic       tck_q;
    logic [2:0] since_fall;
    logic [3:0] hi_cnt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Age of last test-clock fall, run of high mode-select rises
    always @(posedge sys_clk) begin
        tck_q <= tck;
        if (sys_rst) begin
            since_fall <= 3'h7;
            hi_cnt     <= 4'h0;
        end else begin
            if (tck_q && !tck) since_fall <= 3'h0;
            else if (since_fall != 3'h7) since_fall <= since_fall + 3'h1;
            if (!tck_q && tck) hi_cnt <= !tms ? 4'h0 : (hi_cnt == 4'hF) ? hi_cnt : hi_cnt + 4'h1;
        end
    end

    property p_reset_idle;
        $fell(sys_rst) |-> !tdo_oe && !pin_test_drive && (pin_test_value == '0);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    property p_tdo_when;
        $changed(tdo) |-> since_fall <= 3'h5;
    endproperty
    a_tdo_when: assert property (p_tdo_when) else $error("tdo moved away from a fall");
    property p_oe_when;
        $changed(tdo_oe) |-> since_fall <= 3'h5;
    endproperty
    a_oe_when: assert property (p_oe_when) else $error("tdo_oe moved away from a fall");
    property p_pv_when;
        $changed(pin_test_value) |-> since_fall <= 3'h5;
    endproperty
    a_pv_when: assert property (p_pv_when) else $error("pin value moved away from a fall");
    property p_pv_stable;
        tdo_oe |-> $stable(pin_test_value);
    endproperty
    a_pv_stable: assert property (p_pv_stable) else $error("pin value moved during shift");
    property p_tlr_reach;
        hi_cnt == 4'h5 |-> ##[1:12] (!tdo_oe && !pin_test_drive);
    endproperty
    a_tlr_reach: assert property (p_tlr_reach) else $error("five high edges missed reset");
    property p_tlr_hold;
        hi_cnt >= 4'h7 |-> !tdo_oe && !pin_test_drive;
    endproperty
    a_tlr_hold: assert property (p_tlr_hold) else $error("left reset state while held");
    property p_oe_width;
        $rose(tdo_oe) |=> tdo_oe [*6];
    endproperty
    a_oe_width: assert property (p_oe_width) else $error("tdo_oe shorter than a clock");
endmodule

bind bst_tap bst_tap_assertions #(.CHAIN_LEN(CHAIN_LEN)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_capture(pin_capture),
    .pin_test_value(pin_test_value), .pin_test_drive(pin_test_drive));

// *** testbench/bst_tester.sv ***
`timescale 1ns/1ps

module bst_tester (
    input  wire logic sys_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo_pin
);
    // Test clock rests low between steps
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 64 ns test-clock period; returns tdo seen before the fall
    task automatic step(input logic m, input logic d, output logic o);
        repeat (2) @(posedge sys_clk);
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge sys_clk);
        tck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        o = tdo_pin;
        tck <= 1'b0;
    endtask

    // n rises with mode-select high, then idle
    task automatic go_reset(input int n);
        logic o;
        repeat (n) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Scan n bits, least significant first, from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [97:0] din,
                        output logic [97:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule

// *** testbench/test_boundary_scan_tap.sv ***
`timescale 1ns/1ps

module test_boundary_scan_tap;
    localparam logic [10:0] PROD = 11'h2A3; // Arbitrary value
    localparam logic [15:0] PART = 16'h5C71; // Arbitrary value
    localparam logic [3:0]  REV  = 4'h9; // Arbitrary value
    localparam logic [97:0] CAP  = {2'h2, 32'hA5C3_0F96, 32'h1234_5678, 32'h9ABC_DEF0};
    localparam logic [97:0] PAT  = {2'h1, 32'h0F1E_2D3C, 32'h4B5A_6978, 32'h8796_A5B4};
    localparam logic [97:0] IDV  = {66'h0, REV, PART, PROD, 1'b1};

    logic        sys_clk;
    logic        sys_rst;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    wire         tdo_pin;
    logic [97:0] pin_capture;
    logic [97:0] pin_test_value;
    logic        pin_test_drive;
    logic [97:0] d;
    logic [2:0]  codes [5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
    int          n_fail;
    int          check_count;

    assign tdo_pin = tdo_oe ? tdo : 1'bz;

    bst_tap #(.ID_PRODUCER(PROD), .ID_PART(PART), .ID_REVISION(REV)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_capture(pin_capture),
        .pin_test_value(pin_test_value), .pin_test_drive(pin_test_drive));
    bst_tester u_t (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin));

    // ----------------------------------------
    // Checking and ending
    // ----------------------------------------
    task automatic chk(input string what, input logic [97:0] exp, input logic [97:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idcode();
        u_t.go_reset(8);
        u_t.scan(1'b0, 32, '0, d);
        chk("idcode", IDV, d);
        chk("tdo_oe idle", 98'h0, {97'h0, tdo_oe});
    endtask

    task automatic t_bypass();
        foreach (codes[k]) begin
            u_t.scan(1'b1, 3, {95'h0, codes[k]}, d);
            chk("ir capture", 98'h1, d);
            u_t.scan(1'b0, 8, 98'hB5, d);
            chk("bypass", 98'h6A, d);
        end
    endtask

    task automatic t_sample();
        u_t.scan(1'b1, 3, 98'h4, d);
        u_t.scan(1'b0, 98, PAT, d);
        chk("sample capture", CAP, d);
        chk("sample drive", 98'h0, {97'h0, pin_test_drive});
        chk("sample latch", PAT, pin_test_value);
    endtask

    task automatic t_extest();
        u_t.scan(1'b1, 3, 98'h0, d);
        chk("extest drive", 98'h1, {97'h0, pin_test_drive});
        chk("latch held", PAT, pin_test_value);
        u_t.scan(1'b0, 98, ~PAT, d);
        chk("extest capture", CAP, d);
        chk("extest latch", ~PAT, pin_test_value);
    endtask

    task automatic t_tlr();
        logic o;
        u_t.step(1'b1, 1'b0, o);
        u_t.step(1'b0, 1'b0, o);
        u_t.step(1'b0, 1'b0, o);
        u_t.step(1'b0, 1'b1, o);
        u_t.go_reset(5);
        chk("reset drive", 98'h0, {97'h0, pin_test_drive});
        chk("reset tdo_oe", 98'h0, {97'h0, tdo_oe});
        u_t.scan(1'b0, 32, '0, d);
        chk("reset idcode", IDV, d);
    endtask

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Hang guard
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        check_count = 0;
        sys_rst = 1'b1;
        pin_capture = CAP;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_tlr();
        end_sim();
    end
endmodule
